//--- rtl/ssa_map.vh
`ifndef SSA_MAP_VH
`define SSA_MAP_VH

// register byte addresses on the plain register port
`define SSA_ADDR_MODE       16'h251C
`define SSA_ADDR_MEM_LO     16'h2710
`define SSA_ADDR_MEM_HI     16'h2714
`define SSA_ADDR_SEGLEN     16'h271A
`define SSA_ADDR_LOOPS      16'h2724
`define SSA_ADDR_POST       16'h2774
`define SSA_ADDR_CMD        16'h2800
`define SSA_ADDR_STATUS     16'h2804
`define SSA_ADDR_SEGDONE    16'h2808
`define SSA_ADDR_CFG        16'h280C

// operating mode codes
`define SSA_MODE_STD        32'h0001_0000
`define SSA_MODE_FIFO       32'h0010_0000

// reset values
`define SSA_RST_MODE        32'h0000_0000
`define SSA_RST_MEM         64'h0000_0000_0000_0000
`define SSA_RST_SEGLEN      32'h0000_0000
`define SSA_RST_LOOPS       32'h0000_0000
`define SSA_RST_POST        32'h0000_0000
`define SSA_RST_CFG         5'h01

// command, status and config bit positions
`define SSA_CMD_START       0
`define SSA_CMD_STOP        1
`define SSA_ST_BUSY         0
`define SSA_ST_ERR          1
`define SSA_ST_DONE         2
`define SSA_CFG_ADC8        4

// limits in samples per channel, single channel, base memory
`define SSA_STEP_HI         64'h0000_0000_0000_0010
`define SSA_STEP_8B         64'h0000_0000_0000_0020
`define SSA_MEM_MIN         64'h0000_0000_0000_0020
`define SSA_PRE_MAX         64'h0000_0000_0000_2000
`define SSA_POST_SPAN_HI    64'h0000_0000_0000_8000
`define SSA_POST_SPAN_8B    64'h0000_0000_0001_0000
`define SSA_SEG_MIN_HI      64'h0000_0000_0000_0020
`define SSA_SEG_MIN_8B      64'h0000_0000_0000_0040
`define SSA_MEM_MAX_HI      64'h0000_0000_8000_0000
`define SSA_MEM_MAX_8B      64'h0000_0001_0000_0000

// one information set per segment per channel
`define SSA_REC_W           256

`endif

//--- rtl/ssa_buf2.v
`timescale 1ns/1ps
`default_nettype none
`include "ssa_map.vh"

module ssa_buf2 #(
  parameter W = `SSA_REC_W
) (
  input  wire         i_clk,
  input  wire         i_rst_b,
  input  wire [W-1:0] i_data,
  input  wire         i_valid,
  output wire         o_ready,
  output reg  [W-1:0] o_data,
  output wire         o_valid,
  input  wire         i_ready
);

  // entry 0 is the head and is the output register itself
  reg  [W-1:0] spare_r;
  reg  [1:0]   cnt_r;
  wire         push;
  wire         pop;

  assign o_ready = (cnt_r != 2'h2);
  assign o_valid = (cnt_r != 2'h0);
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_data  <= {W{1'b0}};
      spare_r <= {W{1'b0}};
      cnt_r   <= 2'h0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (cnt_r == 2'h0) o_data <= i_data;
          else spare_r <= i_data;
          cnt_r <= cnt_r + 2'h1;
        end
        2'b01: begin
          o_data <= spare_r;
          cnt_r  <= cnt_r - 2'h1;
        end
        2'b11: begin
          if (cnt_r == 2'h1) o_data <= i_data;
          else begin
            o_data  <= spare_r;
            spare_r <= i_data;
          end
        end
        default: begin
          cnt_r <= cnt_r;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

//--- rtl/ssa_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "ssa_map.vh"

// Function
// R1: each trigger captures one programmed-length segment
// R2: standard mode stops at total sample count
// R3: host sets total as segment multiple
// R4: mode 65536 selects standard statistics
// R5: mode 1048576 selects streaming statistics
// R6: streaming ignores total, runs until stop/count
// R7: repeat count zero endless, else segment count
// R8: stream only per-segment records, block by block
// R9: one 256-bit record per segment per channel
// R10: maximum size scales with active channels
// R11: wide converters: step 16, stated minima
// R12: wide converters: post-trigger maximum per channels
// R13: byte converters: step 32, stated minima
// R14: byte converters: post-trigger maximum per channels
// R15: wide base memory caps 2G/1G/512M
// R16: all limits counted in samples per channel
// R17: reject values off the step grid
// R18: pre-trigger is segment minus post, checked
// R19: rearm automatically until stop condition
module ssa_ctrl (
  input  wire                 i_clk,
  input  wire                 i_rst_b,
  input  wire [15:0]          i_addr,
  input  wire [31:0]          i_wdata,
  input  wire                 i_wr,
  input  wire                 i_rd,
  output reg  [31:0]          o_rdata,
  input  wire                 i_trig,
  input  wire                 i_smp_valid,
  output wire                 o_capture,
  output reg                  o_trig_mark,
  output reg                  o_seg_end,
  input  wire [`SSA_REC_W-1:0] i_stat_data,
  input  wire                 i_stat_valid,
  output wire                 o_stat_ready,
  output wire [`SSA_REC_W-1:0] o_rec_data,
  output wire                 o_rec_valid,
  input  wire                 i_rec_ready,
  output wire                 o_busy
);

  localparam ST_IDLE  = 3'h0;
  localparam ST_PRE   = 3'h1;
  localparam ST_ARM   = 3'h2;
  localparam ST_POST  = 3'h3;
  localparam ST_FLUSH = 3'h4;

  reg  [31:0] mode_r;
  reg  [63:0] mem_r;
  reg  [31:0] seglen_r;
  reg  [31:0] loops_r;
  reg  [31:0] post_r;
  reg  [4:0]  cfg_r;
  reg  [2:0]  st_r;
  reg  [2:0]  st_nxt;
  reg  [31:0] smp_cnt_r;
  reg  [31:0] seg_cnt_r;
  reg  [63:0] tot_r;
  reg  [33:0] exp_rec_r;
  reg  [33:0] out_rec_r;
  reg         err_r;
  reg         done_r;
  reg         stop_pend_r;
  reg         fifo_r;
  reg         trig_s1_r;
  reg         trig_s2_r;
  reg         trig_s3_r;
  reg         trig_flt_r;

  // checks: every size must sit on the step grid of the converter width
  function off_step;
    input [63:0] val;
    input        adc8;
    begin
      off_step = adc8 ? (val[4:0] != 5'h00) : (val[3:0] != 4'h0); // R17
    end
  endfunction

  function [2:0] chan_count;
    input [3:0] mask;
    begin
      chan_count = {2'h0, mask[0]} + {2'h0, mask[1]} + {2'h0, mask[2]} + {2'h0, mask[3]};
    end
  endfunction

  wire        adc8      = cfg_r[`SSA_CFG_ADC8];
  wire [2:0]  nch       = chan_count(cfg_r[3:0]);
  wire        nch_bad   = (nch != 3'h1) & (nch != 3'h2) & (nch != 3'h4);
  wire [1:0]  shift     = (nch == 3'h4) ? 2'h2 : ((nch == 3'h2) ? 2'h1 : 2'h0);
  wire [63:0] step      = adc8 ? `SSA_STEP_8B : `SSA_STEP_HI;
  wire [63:0] seg64     = {32'h0000_0000, seglen_r};
  wire [63:0] post64    = {32'h0000_0000, post_r};
  wire [63:0] pre64     = seg64 - post64; // R18
  wire [63:0] mem_max   = (adc8 ? `SSA_MEM_MAX_8B : `SSA_MEM_MAX_HI) >> shift; // R10 R15
  wire [63:0] post_max  = ((adc8 ? `SSA_POST_SPAN_8B : `SSA_POST_SPAN_HI) >> shift) - step; // R12 R14
  wire [63:0] seg_min   = adc8 ? `SSA_SEG_MIN_8B : `SSA_SEG_MIN_HI;
  wire        is_std    = (mode_r == `SSA_MODE_STD); // R4
  wire        is_fifo   = (mode_r == `SSA_MODE_FIFO); // R5
  wire        size_bad  = off_step(seg64, adc8) | off_step(post64, adc8) | // R11 R13
                          (seg64 < seg_min) | (seg64 > mem_max) |
                          (post64 < step) | (post64 > post_max) | (post64 >= seg64) |
                          (pre64 < step) | (pre64 > `SSA_PRE_MAX); // R18
  // standard mode also needs a total that holds whole segments
  wire        mem_bad   = off_step(mem_r, adc8) | (mem_r < `SSA_MEM_MIN) | (mem_r > mem_max) | // R2 R10
                          (seglen_r == 32'h0000_0000) || ((mem_r % seg64) != 64'h0); // R3
  wire        cfg_ok    = (is_std & ~size_bad & ~mem_bad & ~nch_bad) |
                          (is_fifo & ~size_bad & ~nch_bad); // R6

  wire        wr_cmd    = i_wr & (i_addr == `SSA_ADDR_CMD);
  wire        start_req = wr_cmd & i_wdata[`SSA_CMD_START];
  wire        stop_req  = wr_cmd & i_wdata[`SSA_CMD_STOP];
  wire        idle      = (st_r == ST_IDLE);
  wire        cfg_wr    = i_wr & idle;

  // trigger pin: three stages, a change counts once stages two and three agree
  // a level held for less than two clocks may be missed; that buys glitch immunity
  wire        trig_flt_nxt = (trig_s2_r == trig_s3_r) ? trig_s3_r : trig_flt_r;
  wire        trig_edge    = trig_flt_nxt & ~trig_flt_r;

  wire        stat_take;
  wire        rec_take  = o_rec_valid & i_rec_ready;
  wire        pre_last  = i_smp_valid & (smp_cnt_r == pre64[31:0] - 32'h0000_0001);
  wire        post_last = i_smp_valid & (smp_cnt_r == post_r - 32'h0000_0001); // R1
  wire [31:0] seg_cnt_inc = seg_cnt_r + 32'h0000_0001;
  wire [63:0] tot_inc     = tot_r + seg64;
  wire        last_seg  = fifo_r ? ((loops_r != 32'h0000_0000) & (seg_cnt_inc == loops_r)) // R7
                                 : (tot_inc >= mem_r); // R2
  wire        seg_close = (st_r == ST_POST) & post_last;
  wire        flush_ok  = (out_rec_r == exp_rec_r);

  assign o_capture = (st_r == ST_PRE) | (st_r == ST_ARM) | (st_r == ST_POST);
  assign o_busy    = ~idle;

  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (start_req & cfg_ok) st_nxt = ST_PRE;
      end
      ST_PRE: begin
        if (stop_req) st_nxt = ST_FLUSH;
        else if (pre_last) st_nxt = ST_ARM;
      end
      ST_ARM: begin
        // samples here are not counted: the pre-trigger window is already full
        if (stop_req) st_nxt = ST_FLUSH;
        else if (trig_edge) st_nxt = ST_POST; // R1
      end
      ST_POST: begin
        // a stop after the trigger lets that segment finish first
        if (post_last) st_nxt = (last_seg | stop_pend_r | stop_req) ? ST_FLUSH : ST_PRE; // R19
      end
      ST_FLUSH: begin
        if (flush_ok) st_nxt = ST_IDLE;
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      trig_s1_r  <= 1'b0;
      trig_s2_r  <= 1'b0;
      trig_s3_r  <= 1'b0;
      trig_flt_r <= 1'b0;
    end else begin
      trig_s1_r  <= i_trig;
      trig_s2_r  <= trig_s1_r;
      trig_s3_r  <= trig_s2_r;
      trig_flt_r <= trig_flt_nxt;
    end
  end

  // configuration is frozen while an acquisition runs
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_r   <= `SSA_RST_MODE;
      mem_r    <= `SSA_RST_MEM;
      seglen_r <= `SSA_RST_SEGLEN;
      loops_r  <= `SSA_RST_LOOPS;
      post_r   <= `SSA_RST_POST;
      cfg_r    <= `SSA_RST_CFG;
    end else if (cfg_wr) begin
      case (i_addr)
        `SSA_ADDR_MODE:   mode_r          <= i_wdata;
        `SSA_ADDR_MEM_LO: mem_r[31:0]     <= i_wdata;
        `SSA_ADDR_MEM_HI: mem_r[63:32]    <= i_wdata;
        `SSA_ADDR_SEGLEN: seglen_r        <= i_wdata;
        `SSA_ADDR_LOOPS:  loops_r         <= i_wdata;
        `SSA_ADDR_POST:   post_r          <= i_wdata;
        `SSA_ADDR_CFG:    cfg_r           <= i_wdata[4:0];
        default:          cfg_r           <= cfg_r;
      endcase
    end
  end

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r        <= ST_IDLE;
      smp_cnt_r   <= 32'h0000_0000;
      seg_cnt_r   <= 32'h0000_0000;
      tot_r       <= 64'h0000_0000_0000_0000;
      exp_rec_r   <= 34'h0_0000_0000;
      out_rec_r   <= 34'h0_0000_0000;
      err_r       <= 1'b0;
      done_r      <= 1'b0;
      stop_pend_r <= 1'b0;
      fifo_r      <= 1'b0;
      o_trig_mark <= 1'b0;
      o_seg_end   <= 1'b0;
    end else begin
      st_r        <= st_nxt;
      o_trig_mark <= (st_r == ST_ARM) & trig_edge & ~stop_req;
      o_seg_end   <= seg_close;
      if (idle & start_req) begin
        err_r       <= ~cfg_ok; // R18
        done_r      <= 1'b0;
        fifo_r      <= is_fifo;
        smp_cnt_r   <= 32'h0000_0000;
        seg_cnt_r   <= 32'h0000_0000;
        tot_r       <= 64'h0000_0000_0000_0000;
        exp_rec_r   <= 34'h0_0000_0000;
        out_rec_r   <= 34'h0_0000_0000;
        stop_pend_r <= 1'b0;
      end else begin
        if (stop_req & ~idle) stop_pend_r <= 1'b1; // R6
        if ((st_r == ST_PRE) & pre_last) smp_cnt_r <= 32'h0000_0000;
        else if ((st_r == ST_ARM) & trig_edge) smp_cnt_r <= 32'h0000_0000;
        else if (seg_close) smp_cnt_r <= 32'h0000_0000;
        else if (((st_r == ST_PRE) | (st_r == ST_POST)) & i_smp_valid) smp_cnt_r <= smp_cnt_r + 32'h0000_0001;
        if (seg_close) begin
          seg_cnt_r <= seg_cnt_inc;
          tot_r     <= tot_inc; // R16
          exp_rec_r <= exp_rec_r + {31'h0000_0000, nch}; // R9
        end
        if (rec_take & (out_rec_r != exp_rec_r)) out_rec_r <= out_rec_r + 34'h0_0000_0001;
        if ((st_r == ST_FLUSH) & flush_ok) done_r <= 1'b1;
      end
    end
  end

  // records are accepted only while one is owed, so nothing between segments leaks out
  assign stat_take = i_stat_valid & o_stat_ready;
  wire   buf_ready;
  // record counters are wide enough for 4G segments of four channels
  reg    [33:0] in_rec_r;
  wire   rec_owed = (in_rec_r != exp_rec_r);
  assign o_stat_ready = buf_ready & rec_owed; // R8

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      in_rec_r <= 34'h0_0000_0000;
    end else if (idle & start_req) begin
      in_rec_r <= 34'h0_0000_0000;
    end else if (stat_take) begin
      in_rec_r <= in_rec_r + 34'h0_0000_0001;
    end
  end

  ssa_buf2 #(
    .W(`SSA_REC_W)
  ) u_buf (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_data  (i_stat_data),
    .i_valid (i_stat_valid & rec_owed),
    .o_ready (buf_ready),
    .o_data  (o_rec_data),
    .o_valid (o_rec_valid),
    .i_ready (i_rec_ready)
  );

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      case (i_addr)
        `SSA_ADDR_MODE:    o_rdata <= mode_r;
        `SSA_ADDR_MEM_LO:  o_rdata <= mem_r[31:0];
        `SSA_ADDR_MEM_HI:  o_rdata <= mem_r[63:32];
        `SSA_ADDR_SEGLEN:  o_rdata <= seglen_r;
        `SSA_ADDR_LOOPS:   o_rdata <= loops_r;
        `SSA_ADDR_POST:    o_rdata <= post_r;
        `SSA_ADDR_CFG:     o_rdata <= {27'h000_0000, cfg_r};
        `SSA_ADDR_STATUS:  o_rdata <= {29'h0000_0000, done_r, err_r, o_busy};
        `SSA_ADDR_SEGDONE: o_rdata <= seg_cnt_r;
        default:           o_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

//--- dv/ssa_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssa_map.vh"

module ssa_ctrl_chk (
  input wire logic                  i_clk,
  input wire logic                  i_rst_b,
  input wire logic [15:0]           i_addr,
  input wire logic [31:0]           i_wdata,
  input wire logic                  i_wr,
  input wire logic                  i_rd,
  input wire logic [31:0]           o_rdata,
  input wire logic                  i_smp_valid,
  input wire logic                  o_capture,
  input wire logic                  o_trig_mark,
  input wire logic                  o_seg_end,
  input wire logic                  o_stat_ready,
  input wire logic [`SSA_REC_W-1:0] o_rec_data,
  input wire logic                  o_rec_valid,
  input wire logic                  i_rec_ready,
  input wire logic                  o_busy
);
  logic [31:0] mode_r;
  logic [31:0] post_r;
  logic [31:0] cnt_r;
  logic        ph_r;
  wire         cmd_wr = i_wr && (i_addr == `SSA_ADDR_CMD);
  wire         bad_mode = (mode_r != `SSA_MODE_STD) && (mode_r != `SSA_MODE_FIFO);

  // shadows of config writes, taken only while idle as the design does
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_r <= 32'h0;
      post_r <= 32'h0;
      cnt_r <= 32'h0;
      ph_r <= 1'b0;
    end else begin
      if (i_wr && !o_busy && i_addr == `SSA_ADDR_MODE) mode_r <= i_wdata;
      if (i_wr && !o_busy && i_addr == `SSA_ADDR_POST) post_r <= i_wdata;
      if (o_trig_mark) ph_r <= 1'b1;
      else if (o_seg_end) ph_r <= 1'b0;
      // the mark cycle already holds the first post-trigger sample
      if (o_trig_mark) cnt_r <= {31'h0, i_smp_valid};
      else if (ph_r && i_smp_valid) cnt_r <= cnt_r + 32'h1;
    end
  end

  default clocking dc @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  sequence rec_stall_s;
    o_rec_valid && !i_rec_ready;
  endsequence
  sequence bad_start_s;
    cmd_wr && i_wdata[`SSA_CMD_START] && !o_busy && bad_mode;
  endsequence
  sequence stop_pre_s;
    cmd_wr && i_wdata[`SSA_CMD_STOP] && o_capture && !ph_r && !o_trig_mark;
  endsequence

  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside its answer cycle");
  capture_busy_a: assert property (o_capture |-> o_busy)
    else $error("capture while idle");
  mark_pulse_a: assert property (o_trig_mark |-> o_capture ##1 !o_trig_mark)
    else $error("trigger mark not a single pulse in capture");
  post_count_a: assert property (o_seg_end |-> cnt_r == post_r)
    else $error("segment end at wrong post sample count");
  rec_hold_a: assert property (rec_stall_s |=> o_rec_valid && $stable(o_rec_data))
    else $error("record lost or changed under stall");
  idle_quiet_a: assert property (!o_busy |-> !o_rec_valid && !o_stat_ready)
    else $error("record traffic while idle");
  bad_start_a: assert property (bad_start_s |=> !o_busy ##1 !o_busy)
    else $error("start accepted with unknown mode");
  stop_pre_a: assert property (stop_pre_s |=> !o_capture)
    else $error("stop before trigger did not end capture");
endmodule

bind ssa_ctrl ssa_ctrl_chk ssa_ctrl_chk_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_smp_valid(i_smp_valid), .o_capture(o_capture),
  .o_trig_mark(o_trig_mark), .o_seg_end(o_seg_end), .o_stat_ready(o_stat_ready), .o_rec_data(o_rec_data),
  .o_rec_valid(o_rec_valid), .i_rec_ready(i_rec_ready), .o_busy(o_busy));
`default_nettype wire

//--- dv/ssa_host_sink.sv
`timescale 1ns/1ps
`default_nettype none

module ssa_host_sink (
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic [255:0] i_data,
  input  wire logic         i_valid,
  input  wire logic         i_stall,
  output logic              o_ready
);
  logic [255:0] got_q [$];

  // the host drains record by record; random stalls push the buffer to full
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ready <= 1'b0;
    end else begin
      if (i_valid && o_ready) got_q.push_back(i_data);
      o_ready <= !i_stall;
    end
  end
endmodule
`default_nettype wire

//--- dv/test_ssa_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssa_map.vh"

module test_ssa_ctrl;
  logic         i_clk = 1'b0;
  logic         i_rst_b = 1'b0;
  logic [15:0]  i_addr = 16'h0;
  logic [31:0]  i_wdata = 32'h0;
  logic         i_wr = 1'b0;
  logic         i_rd = 1'b0;
  logic         i_trig = 1'b0;
  logic         i_smp_valid = 1'b0;
  logic [255:0] i_stat_data = 256'h0;
  logic         i_stat_valid = 1'b0;
  logic         stall = 1'b0;
  logic [31:0]  seed = 32'h9DC0030A;
  logic [31:0]  rd_v;
  logic [7:0]   tcnt = 8'h0;
  logic [255:0] exp_q [$];
  int           err_count = 0;
  int           n_compared = 0;
  int           owed = 0;
  int           nch = 1;
  wire  [31:0]  o_rdata;
  wire  [255:0] o_rec_data;
  wire          o_capture, o_trig_mark, o_seg_end, o_stat_ready, o_rec_valid, o_busy, rec_ready;
  // mode, channel config, segment, post, total: each start must be refused
  logic [159:0] bad [7] = '{{32'h1, 32'h1, 32'h20, 32'h10, 32'h40},
    {32'h0001_0000, 32'h1, 32'h28, 32'h10, 32'h50}, {32'h0001_0000, 32'h1, 32'h40, 32'h10, 32'h60},
    {32'h0001_0000, 32'h1, 32'h2030, 32'h20, 32'h2030}, {32'h0001_0000, 32'h11, 32'h30, 32'h10, 32'h60},
    {32'h0001_0000, 32'hF, 32'h2010, 32'h2000, 32'h2010}, {32'h0001_0000, 32'hF, 32'h20, 32'h10, 32'h2000_0020}};
  logic [15:0]  rst_a [11] = '{`SSA_ADDR_MODE, `SSA_ADDR_MEM_LO, `SSA_ADDR_MEM_HI, `SSA_ADDR_SEGLEN,
    `SSA_ADDR_LOOPS, `SSA_ADDR_POST, `SSA_ADDR_CMD, `SSA_ADDR_STATUS, `SSA_ADDR_SEGDONE, `SSA_ADDR_CFG, 16'h0004};

  always #12.5 i_clk = ~i_clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic int exp_segs(input int total, input int seg);
    return total / seg;
  endfunction

  ssa_ctrl ssa_ctrl_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_trig(i_trig), .i_smp_valid(i_smp_valid), .o_capture(o_capture),
    .o_trig_mark(o_trig_mark), .o_seg_end(o_seg_end), .i_stat_data(i_stat_data), .i_stat_valid(i_stat_valid),
    .o_stat_ready(o_stat_ready), .o_rec_data(o_rec_data), .o_rec_valid(o_rec_valid), .i_rec_ready(rec_ready),
    .o_busy(o_busy));
  ssa_host_sink ssa_host_sink_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_data(o_rec_data), .i_valid(o_rec_valid),
    .i_stall(stall), .o_ready(rec_ready));

  // slow trigger so the input filter always sees a settled level
  always @(posedge i_clk) begin
    tcnt <= tcnt + 8'h1;
    i_trig <= tcnt[3];
    i_smp_valid <= (rnd() % 4) != 0;
    stall <= (rnd() % 8) < 5;
  end

  // statistics engine: one record per active channel for each finished segment
  always @(posedge i_clk) begin
    if (i_stat_valid && o_stat_ready) begin
      exp_q.push_back(i_stat_data);
      owed = owed - 1;
    end
    if (o_seg_end) owed = owed + nch;
    if (!i_stat_valid || o_stat_ready) i_stat_data <= {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
    i_stat_valid <= owed > 0;
  end

  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk256(input logic [255:0] g, input logic [255:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    rd_v = o_rdata;
  endtask

  task automatic setup(input logic [31:0] m, c, s, p, input logic [63:0] t, input logic [31:0] l);
    nch = c[0] + c[1] + c[2] + c[3];
    wr(`SSA_ADDR_MODE, m);
    wr(`SSA_ADDR_CFG, c);
    wr(`SSA_ADDR_SEGLEN, s);
    wr(`SSA_ADDR_POST, p);
    wr(`SSA_ADDR_MEM_LO, t[31:0]);
    wr(`SSA_ADDR_MEM_HI, t[63:32]);
    wr(`SSA_ADDR_LOOPS, l);
    wr(`SSA_ADDR_CMD, 32'h1);
  endtask

  task automatic end_test(input int n_seg, input logic [31:0] st);
    #1;
    repeat (4000) if (o_busy !== 1'b0) begin
      @(posedge i_clk);
      #1;
    end
    chk32({31'h0, o_busy}, 32'h0);
    rd(`SSA_ADDR_STATUS);
    chk32(rd_v, st);
    rd(`SSA_ADDR_SEGDONE);
    chk32(rd_v, 32'(n_seg));
    chk32(32'(exp_q.size()), 32'(n_seg * nch));
    chk32(32'(ssa_host_sink_i.got_q.size()), 32'(exp_q.size()));
    while (exp_q.size() > 0 && ssa_host_sink_i.got_q.size() > 0)
      chk256(ssa_host_sink_i.got_q.pop_front(), exp_q.pop_front());
    exp_q.delete();
    ssa_host_sink_i.got_q.delete();
    $display("test done: %0d segments, status %h", n_seg, st);
  endtask

  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #400000;
    err_count++;
    complete_run();
  end

  initial begin
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'b1;
    foreach (rst_a[k]) begin
      rd(rst_a[k]);
      chk32(rd_v, (rst_a[k] == `SSA_ADDR_CFG) ? {27'h0, `SSA_RST_CFG} : 32'h0);
    end
    $display("test done: reset values");
    for (int k = 0; k < 7; k++) begin
      setup(bad[k][159:128], bad[k][127:96], bad[k][95:64], bad[k][63:32], {32'h0, bad[k][31:0]}, 32'h0);
      end_test(0, 32'h2);
    end
    setup(`SSA_MODE_STD, 32'h1, 32'h20, 32'h10, 64'h40, 32'h0);
    rd(`SSA_ADDR_POST);
    chk32(rd_v, 32'h10);
    end_test(exp_segs(64, 32), 32'h4);
    setup(`SSA_MODE_FIFO, 32'h3, 32'h40, 32'h20, 64'h20, 32'h3);
    end_test(3, 32'h4);
    setup(`SSA_MODE_FIFO, 32'h11, 32'h40, 32'h20, 64'h0, 32'h0);
    repeat (4) @(posedge o_seg_end);
    wr(`SSA_ADDR_SEGLEN, 32'h80);
    @(posedge o_seg_end);
    wr(`SSA_ADDR_CMD, 32'h2);
    end_test(5, 32'h4);
    rd(`SSA_ADDR_SEGLEN);
    chk32(rd_v, 32'h40);
    // four channels, stop lands inside the post-trigger part of the first segment
    setup(`SSA_MODE_FIFO, 32'hF, 32'h40, 32'h20, 64'h0, 32'h0);
    @(posedge o_trig_mark);
    wr(`SSA_ADDR_CMD, 32'h2);
    end_test(1, 32'h4);
    complete_run();
  end
endmodule
`default_nettype wire
